// [core/ccr_pkg.sv]
package ccr_pkg;
    // Register byte offsets (one aligned word each)
    localparam logic [7:0] CCR_OFS_ONE = 8'h00;
    localparam logic [7:0] CCR_OFS_TWO = 8'h04;
    localparam logic [7:0] CCR_OFS_STAT = 8'h08;
    localparam logic [7:0] CCR_OFS_MASK = 8'h0c;
    // Control register field positions
    localparam int CCR_BIT_EN = 7;
    localparam int CCR_BIT_OUT = 6;
    localparam int CCR_BIT_OE = 5;
    localparam int CCR_BIT_POL = 4;
    localparam int CCR_BIT_REF = 2;
    localparam int CCR_CH_LO = 0;
    // Writable bits of a control register
    localparam logic [7:0] CCR_WR_MASK = 8'hb7;
    // Reset value of a control register
    localparam logic [7:0] CCR_CTL_RST = 8'h00;
    // Number of comparators
    localparam int CCR_NCMP = 2;
    // Instruction cycle: four system clocks
    localparam logic [1:0] CCR_PHASES_M1 = 2'h3;
    // AHB transfer type and response
    localparam logic [1:0] CCR_HTRANS_NONSEQ = 2'h2;
    localparam logic CCR_RESP_OKAY = 1'b0;
    // Register bus state
    typedef enum logic [0:0] {
        CCR_IDLE = 1'b0,
        CCR_DATA = 1'b1
    } ccr_bus_e;
endpackage

// [core/ccr_cmp_if.sv]
// Per-comparator control and result bundle
interface ccr_cmp_if;
    import ccr_pkg::*;
    logic [7:0] ctl;      // Control register contents
    logic raw;            // Raw compare from analog core
    logic res;            // Latched polarity-corrected result
    logic live;           // Unlatched polarity-corrected result
    logic rd_strobe;      // Register read or write of this control
    logic mismatch_edge;  // One-cycle pulse on mismatch rise
    modport top (output ctl, output rd_strobe, input res, input live, input mismatch_edge);
    modport unit (input ctl, input raw, input rd_strobe, output res, output live,
                  output mismatch_edge);
endinterface

// [core/ccr_cmp_unit.sv]
// One comparator's result latch and mismatch detector
module ccr_cmp_unit (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Instruction cycle enable
    input wire logic cyc_en,
    // Comparator bundle
    ccr_cmp_if.unit cmp
);
    import ccr_pkg::*;
    logic s1_reg, s2_reg, s3_reg;  // Pin synchroniser
    logic raw_reg;                 // Accepted raw compare
    logic res_reg;                 // Result latched each instruction cycle
    logic ref_reg;                 // Mismatch reference latch
    logic mm_reg;                  // Previous mismatch level
    logic pol_raw;                 // Corrected, stable raw
    logic mismatch;                // Current mismatch level

    // Synchronise raw compare, accept when stages agree
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            raw_reg <= 1'b0;
        end else begin
            s1_reg <= cmp.raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // A change counts only once two stages agree
            if (s2_reg == s3_reg) begin
                raw_reg <= s3_reg;
            end
        end
    end

    // polarity inversion applied; disabled reads zero
    assign pol_raw = cmp.ctl[CCR_BIT_EN] & (raw_reg ^ cmp.ctl[CCR_BIT_POL]);
    assign cmp.live = cmp.ctl[CCR_BIT_EN] & (raw_reg ^ cmp.ctl[CCR_BIT_POL]);

    // result relatched once per instruction cycle
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            res_reg <= 1'b0;
        end else if (cyc_en) begin
            res_reg <= pol_raw;
        end
    end
    assign cmp.res = res_reg;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ref_reg <= 1'b0;
        end else if (cmp.rd_strobe) begin
            ref_reg <= res_reg;
        end
    end
    assign mismatch = (ref_reg ^ res_reg) & ~cmp.rd_strobe;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            mm_reg <= 1'b0;
        end else begin
            mm_reg <= mismatch;
        end
    end
    assign cmp.mismatch_edge = mismatch & ~mm_reg;

    // Result changes only on an instruction cycle enable
    a_res_on_cycle: assert property (@(posedge ref_clk) disable iff (!resetn)
        !cyc_en |=> $stable(res_reg))
        else $error("result changed outside instruction cycle");
    // Edge pulse is single cycle
    a_edge_single: assert property (@(posedge ref_clk) disable iff (!resetn)
        cmp.mismatch_edge |=> !cmp.mismatch_edge)
        else $error("mismatch edge held longer than one cycle");
    // Read loads the reference
    a_ref_capture: assert property (@(posedge ref_clk) disable iff (!resetn)
        cmp.rd_strobe |=> ref_reg == $past(res_reg))
        else $error("reference not captured on read");
endmodule // ccr_cmp_unit

// [core/ccr_top.sv]
// Operation
// - Bit 7 enables its comparator
// - Bit 6 reads compare result
// - Result bit read-only, resets zero
// - Pin driven when OE, enabled, output
// - Bit 4 inverts the result
// - Bit 2 picks internal reference input
// - Bits 1:0 pick inverting input pin
// - Second comparator uses identical register
// - Reads capture result into mismatch latch
// - Interrupt set on mismatch edge only
// - Result relatched every instruction cycle
// - Reset clears both control registers
//
// Chosen here: register access over AHB-Lite and the register offsets.
module ccr_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Analog comparator cores
    input wire logic [ccr_pkg::CCR_NCMP-1:0] cmp_raw,
    output logic [ccr_pkg::CCR_NCMP-1:0] cmp_power_on,
    output logic [ccr_pkg::CCR_NCMP-1:0] noninverting_ref_sel,
    output logic [ccr_pkg::CCR_NCMP*2-1:0] inverting_pin_sel,
    // Port pin drivers
    input wire logic [ccr_pkg::CCR_NCMP-1:0] port_direction_bit,
    output logic [ccr_pkg::CCR_NCMP-1:0] pin_out,
    output logic [ccr_pkg::CCR_NCMP-1:0] pin_oe,
    // Interrupt
    output logic irq
);
    import ccr_pkg::*;
    ccr_bus_e state_reg;                 // Bus data phase flag
    logic [7:0] addr_reg;                // Latched address
    logic wr_reg;                        // Latched direction
    logic [1:0] phase_reg;               // Instruction cycle divider
    logic cyc_en;                        // Instruction cycle enable
    logic [CCR_NCMP-1:0] stat_reg;       // Sticky event bits
    logic [CCR_NCMP-1:0] mask_reg;       // Interrupt mask
    logic [CCR_NCMP-1:0] edge_v;         // Event pulses
    logic [7:0] ctl_reg [CCR_NCMP];      // Control registers
    logic addr_ok;                       // Valid address phase
    logic stat_rd;                       // Status read in data phase

    ccr_cmp_if cmp_b [CCR_NCMP] ();

    // Address phase capture
    assign addr_ok = hsel && hready && (htrans == CCR_HTRANS_NONSEQ);
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_reg <= CCR_IDLE;
            addr_reg <= 8'h00;
            wr_reg <= 1'b0;
        end else if (addr_ok) begin
            state_reg <= CCR_DATA;
            addr_reg <= haddr[7:0];
            wr_reg <= hwrite;
        end else begin
            state_reg <= CCR_IDLE;
        end
    end

    // Zero-wait answers, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = CCR_RESP_OKAY;

    // Instruction cycle divider
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end
    assign cyc_en = (phase_reg == CCR_PHASES_M1);

    // Per-comparator register and unit
    genvar gi;
    generate
        for (gi = 0; gi < CCR_NCMP; gi++) begin : g_cmp
            localparam logic [7:0] OFS = (gi == 0) ? CCR_OFS_ONE : CCR_OFS_TWO;
            logic hit;
            assign hit = (state_reg == CCR_DATA) && (addr_reg == OFS);
            // same layout per comparator; reset clears
            always_ff @(posedge ref_clk) begin
                if (!resetn) begin
                    ctl_reg[gi] <= CCR_CTL_RST;
                end else if (hit && wr_reg) begin
                    ctl_reg[gi] <= hwdata[7:0] & CCR_WR_MASK;
                end
            end
            assign cmp_b[gi].ctl = ctl_reg[gi];
            assign cmp_b[gi].raw = cmp_raw[gi];
            assign cmp_b[gi].rd_strobe = hit;
            assign edge_v[gi] = cmp_b[gi].mismatch_edge;
            assign cmp_power_on[gi] = ctl_reg[gi][CCR_BIT_EN];
            assign noninverting_ref_sel[gi] = ctl_reg[gi][CCR_BIT_REF];
            assign inverting_pin_sel[gi*2 +: 2] = ctl_reg[gi][CCR_CH_LO +: 2];
            assign pin_oe[gi] = ctl_reg[gi][CCR_BIT_OE] & ctl_reg[gi][CCR_BIT_EN]
                & ~port_direction_bit[gi];
            assign pin_out[gi] = cmp_b[gi].live & pin_oe[gi];
            ccr_cmp_unit u_unit (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .cyc_en(cyc_en),
                .cmp(cmp_b[gi])
            );
            // Pin drive follows its three conditions
            a_pin_drive: assert property (@(posedge ref_clk) disable iff (!resetn)
                pin_oe[gi] == (ctl_reg[gi][CCR_BIT_OE] && ctl_reg[gi][CCR_BIT_EN]
                && !port_direction_bit[gi]))
                else $error("pin enable wrong");
            // Result bit cannot be written
            a_ro_result: assert property (@(posedge ref_clk) disable iff (!resetn)
                hit && wr_reg |=> !ctl_reg[gi][CCR_BIT_OUT])
                else $error("result bit stored by write");
            // Disabled comparator result reads zero next cycle
            a_off_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
                !ctl_reg[gi][CCR_BIT_EN] && cyc_en |=> !cmp_b[gi].res)
                else $error("disabled comparator shows result");
        end
    endgenerate

    // Status read clears sticky bits
    assign stat_rd = (state_reg == CCR_DATA) && !wr_reg && (addr_reg == CCR_OFS_STAT);

    // sticky events, set wins over clear
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            stat_reg <= '0;
        end else begin
            stat_reg <= (stat_rd ? '0 : stat_reg) | edge_v;
        end
    end

    // Mask register
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            mask_reg <= '0;
        end else if (state_reg == CCR_DATA && wr_reg && addr_reg == CCR_OFS_MASK) begin
            mask_reg <= hwdata[CCR_NCMP-1:0];
        end
    end

    // Level interrupt from unmasked status
    assign irq = |(stat_reg & mask_reg);

    // Read data mux, unmapped reads zero
    always_comb begin
        hrdata = 32'h0000_0000;
        if (state_reg == CCR_DATA && !wr_reg) begin
            case (addr_reg)
                CCR_OFS_ONE: hrdata = {24'h0, ctl_reg[0] | ({7'h0, cmp_b[0].res} << CCR_BIT_OUT)};
                CCR_OFS_TWO: hrdata = {24'h0, ctl_reg[1] | ({7'h0, cmp_b[1].res} << CCR_BIT_OUT)};
                CCR_OFS_STAT: hrdata = {30'h0, stat_reg};
                CCR_OFS_MASK: hrdata = {30'h0, mask_reg};
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    // Control registers return to zero after reset
    a_reset_clear: assert property (@(posedge ref_clk)
        !resetn |=> ctl_reg[0] == CCR_CTL_RST && ctl_reg[1] == CCR_CTL_RST)
        else $error("control not cleared by reset");
    // Event sets status next cycle
    a_event_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
        edge_v[0] |=> stat_reg[0])
        else $error("event lost");
    // Reference select follows register
    a_ref_route: assert property (@(posedge ref_clk) disable iff (!resetn)
        noninverting_ref_sel[1] == ctl_reg[1][CCR_BIT_REF])
        else $error("reference select wrong");
    // Channel select follows register
    a_chan_route: assert property (@(posedge ref_clk) disable iff (!resetn)
        inverting_pin_sel[1:0] == ctl_reg[0][1:0])
        else $error("channel select wrong");
endmodule // ccr_top

// [bench/ccr_analog_model.sv]
// Analog cores: input steering and compare
module ccr_analog_model (
    // Clock
    input wire logic ref_clk,
    // Selections from the registers
    input wire logic [1:0] cmp_power_on,
    input wire logic [1:0] noninverting_ref_sel,
    input wire logic [3:0] inverting_pin_sel,
    // Input voltages, one byte each
    input wire logic [15:0] vref,
    input wire logic [15:0] vpos,
    input wire logic [63:0] vneg,
    // Compare outputs
    output logic [1:0] cmp_raw
);
    timeunit 1ns;
    timeprecision 100ps;
    logic tog = 1'b0;  // Changes every cycle
    // Pattern for a core that is off
    always @(posedge ref_clk) tog <= ~tog;
    // One core per comparator
    always @(posedge ref_clk) begin
        for (int c = 0; c < 2; c++) begin
            if (cmp_power_on[c])
                cmp_raw[c] <= (noninverting_ref_sel[c] ? vref[8*c+:8] : vpos[8*c+:8])
                    > vneg[32*c+8*inverting_pin_sel[2*c+:2]+:8];
            // No stable level while off
            else
                cmp_raw[c] <= tog;
        end
    end
endmodule // ccr_analog_model

// [bench/ccr_top_tb.sv]
// Register block bench
module ccr_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ccr_pkg::*;
    logic ref_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0, dir = 2'h3;
    logic [2:0] hsize = 3'h2;
    logic [15:0] vref = 16'h0, vpos = 16'h0;
    logic [63:0] vneg = 64'h0, note;
    logic [31:0] hrdata, rnd = 32'he005a34e;
    logic hreadyout, hresp, irq, rd_dp = 1'b0;
    logic [1:0] cmp_raw, pw, rs, pin_out, pin_oe, r, oe;
    logic [3:0] ps;
    logic [7:0] v1, v2;
    logic [63:0] notes[$];  // Expected read data with mask
    int bad_count = 0, n_compared = 0, cycles = 0;
    ccr_top i_ccr_top (.ref_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .cmp_raw,
        .cmp_power_on(pw), .noninverting_ref_sel(rs), .inverting_pin_sel(ps),
        .port_direction_bit(dir), .pin_out, .pin_oe, .irq);
    ccr_analog_model i_ccr_analog_model (.ref_clk, .cmp_power_on(pw),
        .noninverting_ref_sel(rs), .inverting_pin_sel(ps), .vref, .vpos, .vneg, .cmp_raw);
    // Clock of 50 ns
    always #25 ref_clk = ~ref_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Expected result bit of one comparator
    function automatic logic res(input int c, input logic [7:0] v);
        logic [7:0] p;
        p = v[CCR_BIT_REF] ? vref[8*c+:8] : vpos[8*c+:8];
        return v[CCR_BIT_EN] & ((p > vneg[32*c+8*v[1:0]+:8]) ^ v[CCR_BIT_POL]);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One single AHB transfer
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= CCR_HTRANS_NONSEQ;
        hsel <= 1'b1;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        notes.push_back({m, e});
        xfer(a, 1'b0, 32'h0);
    endtask
    task automatic settle;
        repeat (16) @(posedge ref_clk);
    endtask
    // Read data watcher
    always @(posedge ref_clk) begin
        if (rd_dp && notes.size() > 0) begin
            note = notes.pop_front();
            check(hrdata & note[63:32], note[31:0]);
            check(hresp, CCR_RESP_OKAY);
        end
        rd_dp <= hsel && hreadyout && htrans == CCR_HTRANS_NONSEQ && !hwrite;
    end
    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rd(CCR_OFS_ONE, 32'hffffffff, 32'h0);
        rd(CCR_OFS_TWO, 32'hffffffff, 32'h0);
        rd(32'h10, 32'hffffffff, 32'h0);
        check(pw, 2'h0);
        // Random settings, every channel code
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            v1 = {rnd[7:2], i[1:0]};
            v2 = {rnd[15:10], ~i[1:0]};
            dir <= rnd[17:16];
            vref <= rnd[31:16] | 16'h0101;
            rnd = lfsr(rnd);
            vpos <= rnd[15:0] | 16'h0101;
            vneg <= {rnd, ~rnd} & {8{8'hfe}};
            xfer(CCR_OFS_ONE, 1'b1, {24'h0, v1});
            xfer(CCR_OFS_TWO, 1'b1, {24'h0, v2});
            settle();
            r = {res(1, v2), res(0, v1)};
            oe = {v2[5] & v2[7], v1[5] & v1[7]} & ~dir;
            rd(CCR_OFS_ONE, 32'hffffffff, {24'h0, v1 & CCR_WR_MASK | r[0] << 6});
            rd(CCR_OFS_TWO, 32'hffffffff, {24'h0, v2 & CCR_WR_MASK | r[1] << 6});
            check(pw, {v2[7], v1[7]});
            check(rs, {v2[2], v1[2]});
            check(ps, {v2[1:0], v1[1:0]});
            check(pin_oe, oe);
            check(pin_out, oe & r);
        end
        // Mismatch events and interrupt
        xfer(CCR_OFS_TWO, 1'b1, 32'h0);
        xfer(CCR_OFS_ONE, 1'b1, 32'h80);
        xfer(CCR_OFS_MASK, 1'b1, 32'h3);
        vpos[7:0] <= 8'hf1;
        vneg[7:0] <= 8'h10;
        settle();
        rd(CCR_OFS_STAT, 32'h0, 32'h0);
        rd(CCR_OFS_MASK, 32'hffffffff, 32'h3);
        rd(CCR_OFS_ONE, 32'hffffffff, 32'hc0);
        vneg[7:0] <= 8'hfe;
        settle();
        check(irq, 1'b1);
        rd(CCR_OFS_STAT, 32'hffffffff, 32'h1);
        @(posedge ref_clk);
        check(irq, 1'b0);
        settle();
        rd(CCR_OFS_STAT, 32'hffffffff, 32'h0);
        xfer(CCR_OFS_MASK, 1'b1, 32'h0);
        vneg[7:0] <= 8'h10;
        settle();
        rd(CCR_OFS_STAT, 32'hffffffff, 32'h0);
        vneg[7:0] <= 8'hfe;
        settle();
        check(irq, 1'b0);
        rd(CCR_OFS_STAT, 32'hffffffff, 32'h1);
        xfer(CCR_OFS_ONE, 1'b1, 32'hd0);
        settle();
        rd(CCR_OFS_ONE, 32'hffffffff, 32'hd0);
        settle();
        // Reset in mid-run returns controls and status to zero
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rd(CCR_OFS_ONE, 32'hffffffff, 32'h0);
        rd(CCR_OFS_STAT, 32'hffffffff, 32'h0);
        check(pw, 2'h0);
        check(irq, 1'b0);
        settle();
        tally_and_finish();
    end
endmodule // ccr_top_tb
